// ### inc/npu_pkg.sv
// Shared formats, field positions and constant encodings of the NaN unit
package npu_pkg;

  localparam int DATA_W     = 64;
  localparam int FRAC_MAX_W = 52;

  typedef enum logic [1:0] {
    FMT_HALF,
    FMT_SINGLE,
    FMT_DOUBLE
  } npu_fmt_t;

  typedef enum logic [1:0] {
    OP_ARITH,
    OP_CVT_H2S,
    OP_CVT_S2H
  } npu_op_t;

  // Half precision field layout
  localparam int H_SIGN    = 15;
  localparam int H_EXP_LSB = 10;
  localparam int H_EXP_W   = 5;
  localparam int H_FRAC_W  = 10;

  // Single precision field layout
  localparam int S_SIGN    = 31;
  localparam int S_EXP_LSB = 23;
  localparam int S_EXP_W   = 8;
  localparam int S_FRAC_W  = 23;

  // Double precision field layout
  localparam int D_SIGN    = 63;
  localparam int D_EXP_LSB = 52;
  localparam int D_EXP_W   = 11;
  localparam int D_FRAC_W  = 52;

  // Payload bits dropped when a single NaN narrows to half
  localparam int S2H_DROP  = S_FRAC_W - H_FRAC_W;

  // Reserved default indefinite quiet NaN, one per precision
  localparam logic [DATA_W-1:0] H_INDEF = 64'h0000_0000_0000_fe00;
  localparam logic [DATA_W-1:0] S_INDEF = 64'h0000_0000_ffc0_0000;
  localparam logic [DATA_W-1:0] D_INDEF = 64'hfff8_0000_0000_0000;

  // Reset values
  localparam logic [DATA_W-1:0] RESULT_RST = 64'h0000_0000_0000_0000;

endpackage

// ### inc/npu_cls_if.sv
// Operand classification bundle between the NaN unit and its classifiers
interface npu_cls_if;
  logic [npu_pkg::DATA_W-1:0]     value;
  npu_pkg::npu_fmt_t              fmt;
  logic                           isNan;
  logic                           isQuiet;
  logic [npu_pkg::FRAC_MAX_W-1:0] frac;
  logic [npu_pkg::DATA_W-1:0]     quieted;

  modport user (
    output value,
    output fmt,
    input  isNan,
    input  isQuiet,
    input  frac,
    input  quieted
  );

  modport cls (
    input  value,
    input  fmt,
    output isNan,
    output isQuiet,
    output frac,
    output quieted
  );
endinterface

// ### logic/npu_classify.sv
// NaN detection, quiet/signal split and quieting of one encoding
module npu_classify (
  // Operand in, classification out
  npu_cls_if.cls c
);

  wire logic                           expOnes;
  wire logic                           topBit;
  wire logic [npu_pkg::FRAC_MAX_W-1:0] fracField;
  wire logic [npu_pkg::DATA_W-1:0]     quietMask;

  assign expOnes =
    (c.fmt == npu_pkg::FMT_HALF) ?
      &c.value[npu_pkg::H_EXP_LSB +: npu_pkg::H_EXP_W] :
    (c.fmt == npu_pkg::FMT_SINGLE) ?
      &c.value[npu_pkg::S_EXP_LSB +: npu_pkg::S_EXP_W] :
      &c.value[npu_pkg::D_EXP_LSB +: npu_pkg::D_EXP_W];

  assign fracField =
    (c.fmt == npu_pkg::FMT_HALF) ?
      npu_pkg::FRAC_MAX_W'(c.value[npu_pkg::H_FRAC_W-1:0]) :
    (c.fmt == npu_pkg::FMT_SINGLE) ?
      npu_pkg::FRAC_MAX_W'(c.value[npu_pkg::S_FRAC_W-1:0]) :
      c.value[npu_pkg::D_FRAC_W-1:0];

  assign topBit =
    (c.fmt == npu_pkg::FMT_HALF)   ? c.value[npu_pkg::H_FRAC_W-1] :
    (c.fmt == npu_pkg::FMT_SINGLE) ? c.value[npu_pkg::S_FRAC_W-1] :
                                     c.value[npu_pkg::D_FRAC_W-1];

  // Only the top fraction bit; sign, exponent, payload stay
  assign quietMask =
    (c.fmt == npu_pkg::FMT_HALF)   ? 64'h1 << (npu_pkg::H_FRAC_W - 1) :
    (c.fmt == npu_pkg::FMT_SINGLE) ? 64'h1 << (npu_pkg::S_FRAC_W - 1) :
                                     64'h1 << (npu_pkg::D_FRAC_W - 1);

  assign c.isNan   = expOnes & (|fracField);
  assign c.isQuiet = topBit;
  assign c.frac    = fracField;
  // Non-NaN values pass untouched, so this also guards finished results
  assign c.quieted = c.isNan ? (c.value | quietMask) : c.value;

endmodule

// ### logic/npu_nan_unit.sv
// NaN result selection and invalid-operation signalling stage
module npu_nan_unit (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  // Operation request from the pipeline
  input  wire logic                       inValid,
  input  npu_pkg::npu_op_t                opKind,
  input  npu_pkg::npu_fmt_t               fmt,
  input  wire logic                       twoSrc,
  input  wire logic                       faultOnQnan,
  input  wire logic                       arithInvalid,
  input  wire logic [npu_pkg::DATA_W-1:0] srcA,
  input  wire logic [npu_pkg::DATA_W-1:0] srcB,
  input  wire logic [npu_pkg::DATA_W-1:0] arithResult,
  // Control
  input  wire logic                       invMasked,
  input  wire logic                       vectorMode,
  input  wire logic                       flagClear,
  // Result to writeback
  output logic                            outValid,
  output logic      [npu_pkg::DATA_W-1:0] result,
  output logic                            invalidExc,
  output logic                            writeSuppress,
  output logic                            formatError,
  output logic                            invalidFlag
);

  npu_cls_if ifA ();
  npu_cls_if ifB ();
  npu_cls_if ifR ();

  npu_classify uClsA (.c(ifA.cls));
  npu_classify uClsB (.c(ifB.cls));
  npu_classify uClsR (.c(ifR.cls));

  logic                       outValid_r;
  logic [npu_pkg::DATA_W-1:0] result_r;
  logic                       invalidExc_r;
  logic                       writeSuppress_r;
  logic                       formatError_r;
  logic                       invalidFlag_r;
  logic                       invalidFlag_nxt;

  wire logic                       isCvt;
  wire npu_pkg::npu_fmt_t          resFmt;
  wire logic                       nanA;
  wire logic                       nanB;
  wire logic                       sigA;
  wire logic                       sigB;
  wire logic                       anyNan;
  wire logic                       anySig;
  wire logic                       anyQuiet;
  wire logic                       halfMisuse;
  wire logic                       halfInArith;
  wire logic                       badH2sSrc;
  wire logic                       badS2hSrc;
  wire logic                       cvtTwoSrc;
  wire logic                       invCond;
  wire logic                       aLarger;
  wire logic                       stackPickA;
  wire logic                       pickA;
  wire logic [npu_pkg::DATA_W-1:0] nanPick;
  wire logic [npu_pkg::DATA_W-1:0] cvtH2s;
  wire logic [npu_pkg::DATA_W-1:0] cvtS2h;
  wire logic [npu_pkg::DATA_W-1:0] cvtNan;
  wire logic [npu_pkg::DATA_W-1:0] indef;
  wire logic [npu_pkg::DATA_W-1:0] resultNxt;
  wire logic                       raise;
  wire logic                       suppress;
  wire logic                       flagSet;

  assign isCvt  = (opKind != npu_pkg::OP_ARITH);
  assign resFmt = (opKind == npu_pkg::OP_CVT_H2S) ? npu_pkg::FMT_SINGLE :
                  (opKind == npu_pkg::OP_CVT_S2H) ? npu_pkg::FMT_HALF :
                                                    fmt;

  assign ifA.value = srcA;
  assign ifA.fmt   = fmt;
  assign ifB.value = srcB;
  assign ifB.fmt   = fmt;
  assign ifR.value = arithResult;
  assign ifR.fmt   = resFmt;

  // Second source only counts on two-operand operations
  assign nanA     = ifA.isNan;
  assign nanB     = twoSrc & ifB.isNan;
  assign sigA     = nanA & ~ifA.isQuiet;
  assign sigB     = nanB & ~ifB.isQuiet;
  assign anyNan   = nanA | nanB;
  assign anySig   = sigA | sigB;
  assign anyQuiet = (nanA & ifA.isQuiet) | (nanB & ifB.isQuiet);

  // Half values are legal only as conversion source or target
  assign halfInArith = (opKind == npu_pkg::OP_ARITH) &
                       (fmt == npu_pkg::FMT_HALF);
  assign badH2sSrc   = (opKind == npu_pkg::OP_CVT_H2S) &
                       (fmt != npu_pkg::FMT_HALF);
  assign badS2hSrc   = (opKind == npu_pkg::OP_CVT_S2H) &
                       (fmt != npu_pkg::FMT_SINGLE);
  // Conversions take one operand only
  assign cvtTwoSrc   = isCvt & twoSrc;
  assign halfMisuse  = halfInArith | badH2sSrc | badS2hSrc |
                       cvtTwoSrc;

  assign invCond = anySig | (faultOnQnan & anyQuiet) | arithInvalid;

  // Stack mode: quiet beats signaling, else larger significand, tie to A
  assign aLarger    = (ifA.frac >= ifB.frac);
  assign stackPickA = (sigA != sigB) ? ~sigA :
                                       aLarger;
  // Vector mode always takes the first source when both are NaNs
  assign pickA = ~nanB | (nanA & (vectorMode | stackPickA));
  // Quieted form leaves an already quiet NaN unchanged
  assign nanPick = pickA ? ifA.quieted :
                           ifB.quieted;

  // NaN through a conversion keeps sign and leading payload, quieted
  assign cvtH2s = npu_pkg::DATA_W'({srcA[npu_pkg::H_SIGN],
                                    {npu_pkg::S_EXP_W{1'b1}},
                                    1'b1,
                                    srcA[npu_pkg::H_FRAC_W-2:0],
                                    {npu_pkg::S2H_DROP{1'b0}}});
  // Narrowing drops the low payload bits of the single
  assign cvtS2h = npu_pkg::DATA_W'({srcA[npu_pkg::S_SIGN],
                                    {npu_pkg::H_EXP_W{1'b1}},
                                    1'b1,
                                    srcA[npu_pkg::S_FRAC_W-2:
                                         npu_pkg::S2H_DROP]});
  assign cvtNan = (opKind == npu_pkg::OP_CVT_H2S) ? cvtH2s : cvtS2h;

  // Indefinite follows the result format, not the source format
  assign indef = (resFmt == npu_pkg::FMT_HALF)   ? npu_pkg::H_INDEF :
                 (resFmt == npu_pkg::FMT_SINGLE) ? npu_pkg::S_INDEF :
                                                   npu_pkg::D_INDEF;

  // Finished results also pass the quieting guard
  assign resultNxt = (isCvt & nanA)  ? cvtNan :
                     anyNan          ? nanPick :
                     arithInvalid    ? indef :
                                       ifR.quieted;

  // A format fault is reported as such, never as an invalid trap
  assign raise    = invCond & ~invMasked & ~halfMisuse;
  assign suppress = raise | halfMisuse;
  assign flagSet  = inValid & invCond & invMasked & ~halfMisuse;

  // New event wins over a clear in the same cycle
  assign invalidFlag_nxt = flagSet ? 1'b1 :
                           flagClear ? 1'b0 :
                                       invalidFlag_r;

  // Pulses stand one cycle; the result holds until the next request
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      outValid_r <= 1'b0;
    end else begin
      outValid_r <= inValid;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      result_r <= npu_pkg::RESULT_RST;
    end else if (inValid) begin
      result_r <= resultNxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      invalidExc_r <= 1'b0;
    end else begin
      invalidExc_r <= inValid & raise;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      writeSuppress_r <= 1'b0;
    end else begin
      writeSuppress_r <= inValid & suppress;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      formatError_r <= 1'b0;
    end else begin
      formatError_r <= inValid & halfMisuse;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      invalidFlag_r <= 1'b0;
    end else begin
      invalidFlag_r <= invalidFlag_nxt;
    end
  end

  assign outValid      = outValid_r;
  assign result        = result_r;
  assign invalidExc    = invalidExc_r;
  assign writeSuppress = writeSuppress_r;
  assign formatError   = formatError_r;
  assign invalidFlag   = invalidFlag_r;

endmodule

// ### tb/npu_nan_unit_asserts.sv
// Port checker of the NaN result selection unit
module npu_nan_unit_asserts (
  // Unit inputs
  input wire logic mclk, rstn, inValid, twoSrc, faultOnQnan,
  input wire logic arithInvalid, invMasked, vectorMode, flagClear,
  input npu_pkg::npu_op_t opKind,
  input npu_pkg::npu_fmt_t fmt,
  input wire logic [npu_pkg::DATA_W-1:0] srcA, srcB, arithResult,
  // Unit outputs
  input wire logic outValid, invalidExc, writeSuppress, formatError,
  input wire logic invalidFlag,
  input wire logic [npu_pkg::DATA_W-1:0] result
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire arithS = inValid && opKind == npu_pkg::OP_ARITH
                && fmt == npu_pkg::FMT_SINGLE;
  wire sNanA = srcA[30:23] == 8'hff && srcA[22:0] != 23'h0 && !srcA[22];
  wire sNanR = result[30:23] == 8'hff && result[22:0] != 23'h0
               && !result[22];
  wire halfAr = inValid && opKind == npu_pkg::OP_ARITH
                && fmt == npu_pkg::FMT_HALF;
  sequence sigReq;
    arithS && sNanA;
  endsequence
  latency_a: assert property (inValid |=> outValid)
    else $error("outValid missing");
  idle_a: assert property (!inValid |=> !outValid)
    else $error("outValid without request");
  exc_supp_a: assert property (
    invalidExc |-> writeSuppress && outValid)
    else $error("exception without suppress");
  unmasked_sig_a: assert property (
    sigReq ##0 !invMasked |=> invalidExc && writeSuppress)
    else $error("signaling NaN not trapped");
  masked_sig_a: assert property (
    sigReq ##0 invMasked |=> invalidFlag && !writeSuppress)
    else $error("masked signaling NaN mishandled");
  quiet_one_a: assert property (
    sigReq ##0 !twoSrc |=>
    result[31:0] == ($past(srcA[31:0]) | 32'h0040_0000))
    else $error("quieting wrong");
  flag_hold_a: assert property (
    invalidFlag && !flagClear |=> invalidFlag)
    else $error("sticky flag lost");
  flag_clr_a: assert property (
    flagClear && !inValid |=> !invalidFlag)
    else $error("flag not cleared");
  half_arith_a: assert property (
    halfAr |=> formatError && !invalidExc)
    else $error("half arithmetic accepted");
  no_snan_a: assert property (
    arithS |=> !sNanR)
    else $error("signaling NaN produced");
endmodule

bind npu_nan_unit npu_nan_unit_asserts chk (.mclk, .rstn, .inValid,
  .twoSrc, .faultOnQnan, .arithInvalid, .invMasked, .vectorMode,
  .flagClear, .opKind, .fmt, .srcA, .srcB, .arithResult, .outValid,
  .invalidExc, .writeSuppress, .formatError, .invalidFlag, .result);

// ### tb/npu_wb_model.sv
// Writeback stage model taking results from the NaN unit
module npu_wb_model (
  // Result side
  input wire logic mclk, rstn, outValid, writeSuppress,
  input wire logic [npu_pkg::DATA_W-1:0] result,
  // Destination state
  output logic [npu_pkg::DATA_W-1:0] destReg
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      destReg <= '0;
    end else if (outValid && !writeSuppress) begin
      destReg <= result;
    end
  end
endmodule

// ### tb/npu_nan_unit_tb.sv
// Self-checking bench of the NaN result selection unit
module npu_nan_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SN = 32'h7f81_2345, SNQ = 32'h7fc1_2345;
  localparam logic [31:0] SN2 = 32'h7f90_0000, SN2Q = 32'h7fd0_0000;
  localparam logic [31:0] QN = 32'h7fc0_0abc, QN2 = 32'hffc0_1000;
  localparam logic [31:0] NRM = 32'h3f80_0000;
  logic mclk, rstn, inValid, twoSrc, faultOnQnan, arithInvalid;
  logic invMasked, vectorMode, flagClear;
  npu_pkg::npu_op_t opKind;
  npu_pkg::npu_fmt_t fmt;
  logic [63:0] srcA, srcB, arithResult, result, destReg;
  logic outValid, invalidExc, writeSuppress, formatError, invalidFlag;
  int error_cnt, n_compared, cycles;
  npu_nan_unit uut (.mclk, .rstn, .inValid, .opKind, .fmt, .twoSrc,
    .faultOnQnan, .arithInvalid, .srcA, .srcB, .arithResult, .invMasked,
    .vectorMode, .flagClear, .outValid, .result, .invalidExc,
    .writeSuppress, .formatError, .invalidFlag);
  npu_wb_model wb (.mclk, .rstn, .outValid, .writeSuppress, .result,
    .destReg);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      final_report();
    end
  end
  task check(input string n, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (e !== g) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // One request, result sampled once it is registered
  task go(input logic [63:0] a, input logic [63:0] b, input logic two);
    @(posedge mclk);
    #1;
    srcA = a;
    srcB = b;
    twoSrc = two;
    inValid = 1'b1;
    @(posedge mclk);
    #1;
    inValid = 1'b0;
    check("outValid", 1, outValid);
  endtask
  task t_one();
    go(SN, 0, 0);
    check("result", SNQ, result);
    check("invalidFlag", 1, invalidFlag);
    check("invalidExc", 0, invalidExc);
    go(QN, 0, 0);
    check("result", QN, result);
    go(32'hff80_0001, 0, 0);
    check("result", 32'hffc0_0001, result);
  endtask
  task pair(input logic [31:0] a, b, es, ev);
    vectorMode = 1'b0;
    go(a, b, 1);
    check("stack result", es, result);
    vectorMode = 1'b1;
    go(a, b, 1);
    check("vector result", ev, result);
  endtask
  task t_pairs();
    pair(SN, QN, QN, SNQ);
    pair(QN, SN, QN, QN);
    pair(SN, SN2, SN2Q, SNQ);
    pair(QN, QN2, QN2, QN);
    pair(SN, NRM, SNQ, SNQ);
    pair(NRM, QN, QN, QN);
  endtask
  task t_unmask();
    invMasked = 1'b0;
    go(NRM, 0, 0);
    go(SN, 0, 0);
    check("invalidExc", 1, invalidExc);
    check("writeSuppress", 1, writeSuppress);
    faultOnQnan = 1'b1;
    go(QN, 0, 0);
    check("invalidExc", 1, invalidExc);
    check("destReg", arithResult, destReg);
    faultOnQnan = 1'b0;
    go(QN, 0, 0);
    check("invalidExc", 0, invalidExc);
    check("writeSuppress", 0, writeSuppress);
    check("destReg", arithResult, destReg);
  endtask
  task t_indef();
    invMasked = 1'b1;
    arithInvalid = 1'b1;
    go(NRM, NRM, 1);
    check("result", npu_pkg::S_INDEF, result);
    check("destReg", QN, destReg);
    fmt = npu_pkg::FMT_DOUBLE;
    go(64'h3ff0_0000_0000_0000, 0, 0);
    check("result", npu_pkg::D_INDEF, result);
    arithInvalid = 1'b0;
    go(64'hfff0_0000_0000_0000, 0, 0);
    check("result", arithResult, result);
    arithResult = 64'h7ff0_0000_0000_0001;
    go(64'h3ff0_0000_0000_0000, 0, 0);
    check("result", 64'h7ff8_0000_0000_0001, result);
    arithResult = 64'h0000_0000_4000_0000;
  endtask
  task t_half();
    fmt = npu_pkg::FMT_HALF;
    go(16'h3c00, 0, 0);
    check("formatError", 1, formatError);
    opKind = npu_pkg::OP_CVT_H2S;
    go(16'h7d01, 0, 0);
    check("result", 32'h7fe0_2000, result);
    check("formatError", 0, formatError);
    opKind = npu_pkg::OP_ARITH;
    fmt = npu_pkg::FMT_SINGLE;
  endtask
  task t_flag();
    flagClear = 1'b1;
    go(SN, 0, 0);
    check("invalidFlag", 1, invalidFlag);
    go(NRM, 0, 0);
    check("invalidFlag", 0, invalidFlag);
    flagClear = 1'b0;
  endtask
  task final_report();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    {rstn, inValid, twoSrc, faultOnQnan, arithInvalid} = 5'h00;
    {vectorMode, flagClear} = 2'h0;
    invMasked = 1'b1;
    opKind = npu_pkg::OP_ARITH;
    fmt = npu_pkg::FMT_SINGLE;
    srcA = '0;
    srcB = '0;
    arithResult = 64'h0000_0000_4000_0000;
    repeat (12) @(posedge mclk);
    #1 rstn = 1'b1;
    check("result", 0, result);
    check("invalidFlag", 0, invalidFlag);
    t_one();
    t_pairs();
    t_unmask();
    t_indef();
    t_half();
    t_flag();
    final_report();
  end
endmodule
